/* File: bench/pci_target_model.sv */
// Behavioural PCI target that claims, answers and logs each transaction except in mode 4.
// Assumes the bench resolves shared wires with pull-ups.
`timescale 1ns/1ps

module pci_target_model
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [2:0] mode_in,
  input wire logic frame_n_in,
  input wire logic irdy_n_in,
  input wire logic [63:0] ad_in,
  input wire logic [7:0] cbe_in,
  output logic trdy_n_out,
  output logic devsel_n_out,
  output logic stop_n_out,
  output logic [63:0] ad_out,
  output logic ad_oe_out
);
  // Mode 0 fast, 1 retry, 2 disconnect with data, 3 abort, 4 no claim, 5 wait per phase
  logic active_q;
  logic [3:0] cmd_q;
  logic [31:0] addr_q;
  logic [7:0] be_q;
  logic be_var_q;
  int nph_q;
  int ntr_q;
  logic [63:0] wd_q [0:7];
  logic [3:0] hist_q [0:31];
  logic xfer;

  ////////////////////////////////////////////////////////////
  assign xfer = active_q && !irdy_n_in && !trdy_n_out && !devsel_n_out;
  // Read codes are even; driving starts after the address edge, so no clash
  assign ad_oe_out = active_q && !cmd_q[0] && !devsel_n_out;
  assign ad_out = 64'hA5A5_0000_0000_0000 + 64'(nph_q);

  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      active_q <= 1'b0;
      trdy_n_out <= 1'b1;
      devsel_n_out <= 1'b1;
      stop_n_out <= 1'b1;
      ntr_q <= 0;
    end
    else if (!active_q)
    begin
      if (!frame_n_in && mode_in != 3'h4)
      begin
        active_q <= 1'b1;
        cmd_q <= cbe_in[3:0];
        addr_q <= ad_in[31:0];
        nph_q <= 0;
        be_var_q <= 1'b0;
        devsel_n_out <= 1'b0;
        trdy_n_out <= !(mode_in == 3'h0 || mode_in == 3'h2);
        stop_n_out <= !(mode_in == 3'h1 || mode_in == 3'h2);
        hist_q[ntr_q[4:0]] <= cbe_in[3:0];
        ntr_q <= ntr_q + 1;
      end
    end
    else if (frame_n_in && irdy_n_in)
    begin
      active_q <= 1'b0;
      trdy_n_out <= 1'b1;
      devsel_n_out <= 1'b1;
      stop_n_out <= 1'b1;
    end
    else
    begin
      if (xfer)
      begin
        wd_q[nph_q[2:0]] <= ad_in;
        if (nph_q == 0)
          be_q <= cbe_in;
        else if (cbe_in != be_q)
          be_var_q <= 1'b1;
        nph_q <= nph_q + 1;
        // A stopping target must drop ready after its one transfer
        if (mode_in != 3'h0 || frame_n_in)
          trdy_n_out <= 1'b1;
        if (frame_n_in)
          devsel_n_out <= 1'b1;
      end
      else if (mode_in == 3'h5)
        trdy_n_out <= 1'b0;
      if (mode_in == 3'h3)
      begin
        devsel_n_out <= 1'b1;
        stop_n_out <= 1'b0;
      end
    end
  end
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the PCI command sequencer with a behavioural target.
// Assumes a request-driven arbiter: grant follows request unless the bench holds it off.
`timescale 1ns/1ps

module tb_top;
  import pci_seq_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [31:0] cmd_addr = '0;
  logic [63:0] cmd_data = '0;
  logic [3:0] cmd_be = 4'h5;
  logic [CNT_W-1:0] cmd_count = 16'h0001;
  logic gnt_n = 1'b1;
  logic hold_bus = 1'b0;
  logic [2:0] tmode = 3'h0;
  logic cmd_ready, req_n, ad_oe, cbe_oe, frame_o, frame_oe, irdy_o, irdy_oe, frame_w;
  logic req64_n, req64_oe, rd_valid, done, busy, trdy_n, devsel_n, stop_n, t_ad_oe, irdy_w;
  logic [63:0] ad_o, t_ad, rd_data, ad_w;
  logic [7:0] cbe, cbe_w;
  logic [2:0] status;
  logic [63:0] rd_q [$];
  int mismatches = 0;
  int check_count = 0;
  logic wide_seen = 1'b0;

  ////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  assign ad_w = ad_oe ? ad_o : (t_ad_oe ? t_ad : '1);
  assign cbe_w = cbe_oe ? cbe : 8'hFF;
  assign frame_w = frame_oe ? frame_o : 1'b1;
  assign irdy_w = irdy_oe ? irdy_o : 1'b1;
  always @(negedge clk) gnt_n <= req_n | hold_bus;
  always @(posedge clk) if (rd_valid === 1'b1) rd_q.push_back(rd_data);
  // Address phase edge: frame low while the target has not yet claimed
  always @(posedge clk)
  begin
    if (frame_w === 1'b0 && tgt.active_q === 1'b0)
      wide_seen <= req64_oe && !req64_n;
  end

  pci_master_command_sequencer uut
  (
    .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .CMD_VALID_IN(cmd_valid), .CMD_READY_OUT(cmd_ready),
    .CMD_OP_IN(cmd_op), .CMD_ADDR_IN(cmd_addr), .CMD_DATA_IN(cmd_data), .CMD_BE_IN(cmd_be),
    .CMD_COUNT_IN(cmd_count), .REQ_N_OUT(req_n), .GNT_N_IN(gnt_n), .AD_IN(ad_w),
    .AD_OUT(ad_o), .AD_OE_OUT(ad_oe), .CBE_OUT(cbe), .CBE_OE_OUT(cbe_oe),
    .FRAME_N_IN(frame_w), .FRAME_N_OUT(frame_o), .FRAME_OE_OUT(frame_oe),
    .IRDY_N_IN(irdy_w), .IRDY_N_OUT(irdy_o), .IRDY_OE_OUT(irdy_oe), .REQ64_N_OUT(req64_n),
    .REQ64_OE_OUT(req64_oe), .TRDY_N_IN(trdy_n), .DEVSEL_N_IN(devsel_n),
    .STOP_N_IN(stop_n), .RD_DATA_OUT(rd_data), .RD_VALID_OUT(rd_valid), .DONE_OUT(done),
    .STATUS_OUT(status), .BUSY_OUT(busy)
  );

  pci_target_model tgt
  (
    .clk_in(clk), .rst_n_in(rst_n), .mode_in(tmode), .frame_n_in(frame_w),
    .irdy_n_in(irdy_w), .ad_in(ad_w), .cbe_in(cbe_w), .trdy_n_out(trdy_n),
    .devsel_n_out(devsel_n), .stop_n_out(stop_n), .ad_out(t_ad), .ad_oe_out(t_ad_oe)
  );

  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic give_up(input string what);
    mismatches++;
    $display("timeout waiting for %s", what);
    wrap_up();
  endtask

  // One command, then wait for its completion pulse
  task automatic run(input logic [2:0] op, input logic [31:0] a, input logic [63:0] d,
                     input logic [15:0] n, input logic [2:0] mode);
    int i;
    @(negedge clk);
    tmode = mode;
    rd_q.delete();
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_count = n;
    for (i = 0; i < 50 && cmd_ready !== 1'b1; i++)
      @(negedge clk);
    if (i == 50)
      give_up("ready");
    @(negedge clk);
    cmd_valid = 1'b0;
    for (i = 0; i < 200 && done !== 1'b1; i++)
      @(negedge clk);
    if (i == 200)
      give_up("done");
    chk("released", '0, {59'h0, frame_oe, irdy_oe, ad_oe, cbe_oe, req64_oe});
    chk("idle", 64'h0, 64'(busy));
  endtask

  task automatic xact(input logic [2:0] op, input logic [3:0] code, input int n,
                      input logic [2:0] mode, input bit wide, input bit rd);
    logic [63:0] d;
    logic [63:0] m;
    logic [7:0] be;
    int i;
    // Start near a carry so the increment is seen crossing it
    d = wide ? 64'h0000_0001_FFFF_FFFF : 64'h0000_0000_FFFF_FFFE;
    m = wide ? '1 : 64'h0000_0000_FFFF_FFFF;
    be = {wide ? 4'h0 : 4'hF, op == OP_CFG_WR ? 4'h5 : 4'h0};
    run(op, 32'h0000_1000 + 32'(n), d, 16'(n), mode);
    chk("command", 64'(code), 64'(tgt.cmd_q));
    chk("address", 64'(32'h0000_1000 + 32'(n)), 64'(tgt.addr_q));
    chk("phases", 64'(n), 64'(tgt.nph_q));
    chk("enables", 64'(be), 64'(tgt.be_q));
    chk("enables steady", '0, 64'(tgt.be_var_q));
    chk("wide request", 64'(wide), 64'(wide_seen));
    chk("status", 64'(ST_OK), 64'(status));
    if (rd)
      chk("read beats", 64'(n), 64'(rd_q.size()));
    for (i = 0; i < n; i++)
      if (rd)
        chk("read data", wide ? 64'hA5A5_0000_0000_0000 + 64'(i) : 64'(i), rd_q[i]);
      else
        chk("write data", (d + 64'(i)) & m, tgt.wd_q[i] & m);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_cfg_io;
    xact(OP_CFG_WR, PCI_CFG_WR, 1, 3'h0, 1'b0, 1'b0);
    xact(OP_IO_WR, PCI_IO_WR, 1, 3'h5, 1'b0, 1'b0);
    xact(OP_IO_RD, PCI_IO_RD, 1, 3'h0, 1'b0, 1'b1);
    xact(3'h7, PCI_IO_RD, 1, 3'h0, 1'b0, 1'b1);
    // A count above one must not turn config or I/O into a burst
    run(OP_CFG_WR, 32'h0000_1001, '0, 16'h0003, 3'h0);
    chk("one cfg phase", 64'h1, 64'(tgt.nph_q));
    run(OP_IO_WR, 32'h0000_1001, '0, 16'h0003, 3'h0);
    chk("one io phase", 64'h1, 64'(tgt.nph_q));
    $display("test cfg_io done");
  endtask

  task automatic t_mem32;
    xact(OP_MEM_WR32, PCI_MEM_WR, 1, 3'h0, 1'b0, 1'b0);
    xact(OP_MEM_WR32, PCI_MEM_WR, 4, 3'h0, 1'b0, 1'b0);
    xact(OP_MEM_RD32, PCI_MEM_RD, 1, 3'h5, 1'b0, 1'b1);
    xact(OP_MEM_RD32, PCI_MEM_RD, 3, 3'h5, 1'b0, 1'b1);
    $display("test mem32 done");
  endtask

  task automatic t_mem64;
    xact(OP_MEM_WR64, PCI_MEM_WR, 1, 3'h0, 1'b1, 1'b0);
    xact(OP_MEM_WR64, PCI_MEM_WR, 3, 3'h5, 1'b1, 1'b0);
    xact(OP_MEM_RD64, PCI_MEM_RD, 1, 3'h0, 1'b1, 1'b1);
    xact(OP_MEM_RD64, PCI_MEM_RD, 2, 3'h5, 1'b1, 1'b1);
    $display("test mem64 done");
  endtask

  task automatic t_term;
    logic [2:0] st [0:3];
    int j;
    int n0;
    st = '{ST_RETRY, ST_DISC, ST_TABORT, ST_MABORT};
    for (j = 0; j < 4; j++)
    begin
      n0 = tgt.ntr_q;
      run(OP_MEM_WR32, 32'h0000_2000, '0, 16'h0004, 3'(j + 1));
      chk("end status", 64'(st[j]), 64'(status));
      chk("claimed", 64'(n0 + (j < 3)), 64'(tgt.ntr_q));
      if (j < 3)
        chk("phases moved", 64'(j == 1), 64'(tgt.nph_q));
    end
    $display("test termination done");
  endtask

  // Fill while the bus is withheld, then drain against a stalling target
  task automatic t_fill;
    int k;
    int i;
    int n0;
    int got;
    @(negedge clk);
    n0 = tgt.ntr_q;
    hold_bus = 1'b1;
    tmode = 3'h5;
    for (k = 0; k < 20; k++)
    begin
      @(negedge clk);
      if (cmd_ready !== 1'b1)
        break;
      cmd_valid = 1'b1;
      cmd_op = k[0] ? OP_IO_RD : OP_IO_WR;
      cmd_count = 16'h0001;
    end
    cmd_valid = 1'b0;
    chk("taken before full", 64'h1, 64'(k == 16 || k == 17));
    hold_bus = 1'b0;
    got = 0;
    for (i = 0; i < 2000 && got < k; i++)
    begin
      @(negedge clk);
      got += (done === 1'b1);
    end
    if (got < k)
      give_up("drain");
    for (i = 0; i < k; i++)
      chk("order", 64'(i[0] ? PCI_IO_RD : PCI_IO_WR), 64'(tgt.hist_q[5'(n0 + i)]));
    chk("ready after drain", 64'h1, 64'(cmd_ready));
    $display("test fill_order done");
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_cfg_io();
    t_mem32();
    t_mem64();
    t_term();
    t_fill();
    wrap_up();
  end
endmodule

/* File: src/pci_seq.sv */
// Command FIFO and PCI initiator that turns queued commands into transactions.
// Assumes an external arbiter, pull-ups and a 64-bit capable target for 64-bit ops.
`timescale 1ns/1ps

module cmd_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Depth must be a power of two so the pointers wrap on their own
  assign in_ready_out = (cnt_q != FULL_CNT);
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem[rd_ptr_q];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

module pci_master_command_sequencer
(
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CMD_VALID_IN,
  output logic CMD_READY_OUT,
  input wire logic [2:0] CMD_OP_IN,
  input wire logic [31:0] CMD_ADDR_IN,
  input wire logic [63:0] CMD_DATA_IN,
  input wire logic [3:0] CMD_BE_IN,
  input wire logic [pci_seq_pkg::CNT_W-1:0] CMD_COUNT_IN,
  output logic REQ_N_OUT,
  input wire logic GNT_N_IN,
  input wire logic [63:0] AD_IN,
  output logic [63:0] AD_OUT,
  output logic AD_OE_OUT,
  output logic [7:0] CBE_OUT,
  output logic CBE_OE_OUT,
  input wire logic FRAME_N_IN,
  output logic FRAME_N_OUT,
  output logic FRAME_OE_OUT,
  input wire logic IRDY_N_IN,
  output logic IRDY_N_OUT,
  output logic IRDY_OE_OUT,
  output logic REQ64_N_OUT,
  output logic REQ64_OE_OUT,
  input wire logic TRDY_N_IN,
  input wire logic DEVSEL_N_IN,
  input wire logic STOP_N_IN,
  output logic [63:0] RD_DATA_OUT,
  output logic RD_VALID_OUT,
  output logic DONE_OUT,
  output logic [2:0] STATUS_OUT,
  output logic BUSY_OUT
);
  import pci_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // The unused opcode falls through to an I/O read, so it must also turn the bus around
  function automatic logic is_read(input logic [2:0] op);
    is_read = (op == OP_MEM_RD32) || (op == OP_MEM_RD64) || (op >= OP_IO_RD);
  endfunction

  // Config and I/O always move one phase; a zero count is taken as one
  function automatic logic [CNT_W-1:0] phases(input logic [2:0] op, input logic [CNT_W-1:0] n);
    if ((op == OP_CFG_WR) || (op >= OP_IO_WR) || (n == '0))
    begin
      phases = CNT_ONE;
    end
    else
    begin
      phases = n;
    end
  endfunction

  function automatic logic is_64(input logic [2:0] op);
    is_64 = (op == OP_MEM_WR64) || (op == OP_MEM_RD64);
  endfunction

  function automatic logic [3:0] pci_code(input logic [2:0] op);
    case (op)
      OP_CFG_WR: pci_code = PCI_CFG_WR;
      OP_MEM_WR32, OP_MEM_WR64: pci_code = PCI_MEM_WR;
      OP_MEM_RD32, OP_MEM_RD64: pci_code = PCI_MEM_RD;
      OP_IO_WR: pci_code = PCI_IO_WR;
      default: pci_code = PCI_IO_RD;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  seq_state_t st_q;
  logic f_valid;
  logic [CMD_W-1:0] f_data;
  logic pop;
  logic grant_ok;
  logic [2:0] op_q;
  logic [63:0] data_q;
  logic [3:0] be_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] rem_q;
  logic [2:0] wait_q;
  logic seen_q;
  logic req_q;
  logic ctl_oe_q;
  logic ad_oe_q;
  logic frame_q;
  logic irdy_q;
  logic req64_q;
  logic [63:0] ad_q;
  logic [7:0] cbe_q;
  logic [63:0] rd_data_q;
  logic rd_valid_q;
  logic done_q;
  logic [2:0] status_q;
  logic xfer;
  logic fin;
  logic [2:0] fin_st;
  logic [CNT_W-1:0] f_cnt;

  cmd_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .in_valid_in(CMD_VALID_IN),
    .in_ready_out(CMD_READY_OUT),
    .in_data_in({CMD_OP_IN, CMD_ADDR_IN, CMD_DATA_IN, CMD_BE_IN, CMD_COUNT_IN}),
    .out_valid_out(f_valid),
    .out_ready_in(pop),
    .out_data_out(f_data)
  );

  // Start only on grant with the bus idle, one command at a time
  assign grant_ok = !GNT_N_IN && FRAME_N_IN && IRDY_N_IN;
  assign pop = (st_q == S_REQ) && grant_ok;
  assign f_cnt = f_data[CNT_W-1:0];

  always_comb
  begin
    xfer = (st_q == S_DATA) && irdy_q && !TRDY_N_IN && !DEVSEL_N_IN;
    fin = 1'b0;
    fin_st = ST_OK;
    if (st_q == S_DATA)
    begin
      // Stop ends the transfer; its flavour follows devsel and progress
      if (!STOP_N_IN)
      begin
        fin = 1'b1;
        if (DEVSEL_N_IN)
        begin
          fin_st = ST_TABORT;
        end
        else if (!xfer && (rem_q == cnt_q))
        begin
          fin_st = ST_RETRY;
        end
        else
        begin
          fin_st = ST_DISC;
        end
      end
      else if (xfer && (rem_q == CNT_ONE))
      begin
        fin = 1'b1;
      end
      else if (DEVSEL_N_IN && !seen_q && (wait_q == DEVSEL_WAIT))
      begin
        fin = 1'b1;
        fin_st = ST_MABORT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing and bus pins
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      st_q <= S_IDLE;
      op_q <= OP_CFG_WR;
      data_q <= 64'h0000_0000_0000_0000;
      be_q <= BE_ALL_ON;
      cnt_q <= CNT_ONE;
      rem_q <= CNT_ONE;
      wait_q <= 3'h0;
      seen_q <= 1'b0;
      req_q <= 1'b0;
      ctl_oe_q <= 1'b0;
      ad_oe_q <= 1'b0;
      frame_q <= 1'b0;
      irdy_q <= 1'b0;
      req64_q <= 1'b0;
      ad_q <= 64'h0000_0000_0000_0000;
      cbe_q <= 8'hFF;
    end
    else
    begin
      case (st_q)
        S_IDLE:
        begin
          if (f_valid)
          begin
            req_q <= 1'b1;
            st_q <= S_REQ;
          end
        end
        S_REQ:
        begin
          if (grant_ok)
          begin
            op_q <= f_data[F_OP_LSB +: 3];
            data_q <= f_data[F_DATA_LSB +: 64];
            be_q <= f_data[F_BE_LSB +: 4];
            cnt_q <= phases(f_data[F_OP_LSB +: 3], f_cnt);
            rem_q <= phases(f_data[F_OP_LSB +: 3], f_cnt);
            req_q <= 1'b0;
            ctl_oe_q <= 1'b1;
            ad_oe_q <= 1'b1;
            frame_q <= 1'b1;
            req64_q <= is_64(f_data[F_OP_LSB +: 3]);
            ad_q <= {32'h0000_0000, f_data[F_ADDR_LSB +: 32]};
            cbe_q <= {BE_ALL_OFF, pci_code(f_data[F_OP_LSB +: 3])};
            wait_q <= 3'h0;
            seen_q <= 1'b0;
            st_q <= S_ADDR;
          end
        end
        S_ADDR:
        begin
          // Frame stays only if more than one phase is due
          frame_q <= (cnt_q > CNT_ONE);
          req64_q <= is_64(op_q) && (cnt_q > CNT_ONE);
          irdy_q <= 1'b1;
          ad_oe_q <= !is_read(op_q);
          ad_q <= data_q;
          if (op_q == OP_CFG_WR)
          begin
            cbe_q <= {BE_ALL_OFF, be_q};
          end
          else
          begin
            // No per-phase enables are given, so non-config phases enable the low four lanes, and the upper four only for 64-bit ops
            cbe_q <= {is_64(op_q) ? BE_ALL_ON : BE_ALL_OFF, BE_ALL_ON};
          end
          wait_q <= 3'h1;
          st_q <= S_DATA;
        end
        S_DATA:
        begin
          wait_q <= (wait_q == DEVSEL_WAIT) ? wait_q : wait_q + 3'h1;
          if (!DEVSEL_N_IN)
          begin
            seen_q <= 1'b1;
          end
          if (xfer)
          begin
            rem_q <= rem_q - CNT_ONE;
            // Linear burst: each phase carries the previous value plus one
            if (is_64(op_q))
            begin
              ad_q <= ad_q + 64'h0000_0000_0000_0001;
            end
            else
            begin
              ad_q <= {32'h0000_0000, ad_q[31:0] + 32'h0000_0001};
            end
            if (rem_q == CNT_TWO)
            begin
              frame_q <= 1'b0;
              req64_q <= 1'b0;
            end
          end
          if (fin)
          begin
            // Frame must drop one cycle before irdy releases
            if (frame_q)
            begin
              frame_q <= 1'b0;
              req64_q <= 1'b0;
              st_q <= S_LAST;
            end
            else
            begin
              irdy_q <= 1'b0;
              ad_oe_q <= 1'b0;
              st_q <= S_END;
            end
          end
        end
        S_LAST:
        begin
          irdy_q <= 1'b0;
          ad_oe_q <= 1'b0;
          st_q <= S_END;
        end
        S_END:
        begin
          ctl_oe_q <= 1'b0;
          st_q <= S_IDLE;
        end
        default:
        begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Results toward the user
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      rd_data_q <= 64'h0000_0000_0000_0000;
      rd_valid_q <= 1'b0;
      done_q <= 1'b0;
      status_q <= ST_OK;
    end
    else
    begin
      rd_valid_q <= xfer && is_read(op_q);
      if (xfer && is_read(op_q))
      begin
        rd_data_q <= is_64(op_q) ? AD_IN : {32'h0000_0000, AD_IN[31:0]};
      end
      if (fin)
      begin
        status_q <= fin_st;
      end
      done_q <= (st_q == S_END);
    end
  end

  assign REQ_N_OUT = !req_q;
  assign AD_OUT = ad_q;
  assign AD_OE_OUT = ad_oe_q;
  assign CBE_OUT = cbe_q;
  assign CBE_OE_OUT = ctl_oe_q;
  assign FRAME_N_OUT = !frame_q;
  assign FRAME_OE_OUT = ctl_oe_q;
  assign IRDY_N_OUT = !irdy_q;
  assign IRDY_OE_OUT = ctl_oe_q;
  assign REQ64_N_OUT = !req64_q;
  assign REQ64_OE_OUT = ctl_oe_q;
  assign RD_DATA_OUT = rd_data_q;
  assign RD_VALID_OUT = rd_valid_q;
  assign DONE_OUT = done_q;
  assign STATUS_OUT = status_q;
  assign BUSY_OUT = (st_q != S_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  a_cfg_addr_phase: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (st_q == S_ADDR) && (op_q == OP_CFG_WR) |-> (cbe_q[3:0] == PCI_CFG_WR)
    ##1 (cbe_q[3:0] == be_q) && (ad_q == data_q) && !frame_q)
    else $error("config write phase wrong");
  a_single_frame: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (st_q == S_ADDR) && (cnt_q == CNT_ONE) |=> !frame_q && irdy_q)
    else $error("single phase kept frame");
  a_burst_frame: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (st_q == S_ADDR) && (cnt_q > CNT_ONE) |=> frame_q)
    else $error("burst dropped frame early");
  a_burst_incr32: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    xfer && !fin && (op_q == OP_MEM_WR32)
    |=> ad_q[31:0] == $past(ad_q[31:0]) + 32'h0000_0001)
    else $error("32-bit burst data not incremented");
  a_read_release: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (st_q == S_DATA) && is_read(op_q) |-> !ad_oe_q && ctl_oe_q)
    else $error("read drives address lines in data phase");
  a_req64_addr: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (st_q == S_ADDR) |-> (req64_q == is_64(op_q)))
    else $error("64-bit request mismatch");
  a_burst_incr64: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    xfer && !fin && (op_q == OP_MEM_WR64)
    |=> ad_q == $past(ad_q) + 64'h0000_0000_0000_0001)
    else $error("64-bit burst data not incremented");
  a_io_wr_code: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (st_q == S_ADDR) && (op_q == OP_IO_WR) |-> (cbe_q[3:0] == PCI_IO_WR) ##1 !frame_q)
    else $error("I/O write code wrong");
  a_io_rd_code: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (st_q == S_ADDR) && (op_q == OP_IO_RD) |-> (cbe_q[3:0] == PCI_IO_RD) ##1 !frame_q)
    else $error("I/O read code wrong");
  a_end_release: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    fin |=> !frame_q ##[0:1] (st_q == S_END) && !irdy_q ##1 !ctl_oe_q && done_q)
    else $error("bus not released after end");
  a_mem_enables: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (st_q == S_DATA) && (op_q != OP_CFG_WR) |-> (cbe_q[3:0] == BE_ALL_ON))
    else $error("data phase enables not all on");
  a_start_idle: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (st_q == S_ADDR) |-> $past(FRAME_N_IN) && $past(IRDY_N_IN) && $past(!GNT_N_IN))
    else $error("started on busy bus");
endmodule

/* File: src/pci_seq_pkg.sv */
// Constants, command codes and PCI encodings for the PCI command sequencer.
// Assumes a single PCI clock domain and a synchronous active-low reset.
// Summary of operation
// - Config write: one phase, given address/data/enables
// - 32-bit write, count one: single phase
// - 32-bit write, count above one: burst
// - 32-bit burst data increments by one
// - 32-bit read: single or burst by count
// - 64-bit write, count one: single phase
// - 64-bit write, count above one: burst
// - 64-bit burst data increments by one
// - 64-bit read: single or burst by count
// - I/O write: one phase, given address/data
// - I/O read: one phase at given address
// - I/O write uses I/O write code
// - End and release on done, stop, abort
package pci_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 16;
  localparam int CMD_W = 119;
  localparam int F_OP_LSB = 116;
  localparam int F_ADDR_LSB = 84;
  localparam int F_DATA_LSB = 20;
  localparam int F_BE_LSB = 16;

  ////////////////////////////////////////////////////////////////////////////
  // User command opcodes
  localparam logic [2:0] OP_CFG_WR = 3'h0;
  localparam logic [2:0] OP_MEM_WR32 = 3'h1;
  localparam logic [2:0] OP_MEM_RD32 = 3'h2;
  localparam logic [2:0] OP_MEM_WR64 = 3'h3;
  localparam logic [2:0] OP_MEM_RD64 = 3'h4;
  localparam logic [2:0] OP_IO_WR = 3'h5;
  localparam logic [2:0] OP_IO_RD = 3'h6;

  // PCI bus command codes
  localparam logic [3:0] PCI_IO_RD = 4'h2;
  localparam logic [3:0] PCI_IO_WR = 4'h3;
  localparam logic [3:0] PCI_MEM_RD = 4'h6;
  localparam logic [3:0] PCI_MEM_WR = 4'h7;
  localparam logic [3:0] PCI_CFG_WR = 4'hB;

  // Byte enables are active low on the bus
  localparam logic [3:0] BE_ALL_ON = 4'h0;
  localparam logic [3:0] BE_ALL_OFF = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // Completion status
  localparam logic [2:0] ST_OK = 3'h0;
  localparam logic [2:0] ST_RETRY = 3'h1;
  localparam logic [2:0] ST_DISC = 3'h2;
  localparam logic [2:0] ST_TABORT = 3'h3;
  localparam logic [2:0] ST_MABORT = 3'h4;

  // Cycles after the address phase without a claim before master abort
  localparam logic [2:0] DEVSEL_WAIT = 3'h4;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_TWO = 16'h0002;

  typedef enum logic [2:0] {S_IDLE, S_REQ, S_ADDR, S_DATA, S_LAST, S_END} seq_state_t;

endpackage
